/* rtl/ertp_timer.sv */
`timescale 1ns/1ps
// Overview of operation
// - counting happens only while the timer enable bit is one.
// - eight-bit counter steps once per prescaled timer clock tick.
// - overflow is the counter stepping past 0xFF on a tick.
// - overflow sets the overflow flag; it stays set until software clears it.
// - every overflow while enabled reloads the counter from the reload holding buffer.
// - reload writes go to a holding buffer, moved to active at overflow.
// - flag with interrupt enable raises the interrupt; software clears the flag.
// - clock mode select zero picks high oscillator, one picks low oscillator.
// - rate field 000 divides by 128, halving per step to 111 dividing by 1.
// - pwm output enable zero leaves pins GPIO; one drives pwm onto them while the timer is enabled.
// - mode bit 1 selects one-pulse output; clear gives timer or continuous pwm.
// - reload sets the pwm period, duty register sets the high time.
// - pwm output drops low when the counter equals the duty value.
// - pwm cycle starts high at enable if duty is above the count, at overflow if duty is above reload.
// - one-pulse mode clears pwm output enable at the first overflow after enable.
module ertp_timer (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // oscillator inputs, asynchronous
  input  wire logic        hoscIn,
  input  wire logic        loscIn,
  // pwm and interrupt
  output logic             pwmLevel,
  output logic             pwmPinActive,
  output logic             irqReq
);

  function automatic ertp_pkg::ertp_sel_t regSel(input logic [11:0] a);
    ertp_pkg::ertp_sel_t s;
    s = ertp_pkg::ERTP_SEL_NONE;
    if (a[1:0] == 2'b00) begin
      unique case (a[11:2])
        ertp_pkg::IDX_MODE:   s = ertp_pkg::ERTP_SEL_MODE;
        ertp_pkg::IDX_COUNT:  s = ertp_pkg::ERTP_SEL_COUNT;
        ertp_pkg::IDX_RELOAD: s = ertp_pkg::ERTP_SEL_RELOAD;
        ertp_pkg::IDX_DUTY:   s = ertp_pkg::ERTP_SEL_DUTY;
        ertp_pkg::IDX_CTRL:   s = ertp_pkg::ERTP_SEL_CTRL;
        default:              s = ertp_pkg::ERTP_SEL_NONE;
      endcase
    end
    return s;
  endfunction : regSel

  ertp_pkg::ertp_apb_req_t req;
  ertp_pkg::ertp_sel_t     sel;
  ertp_pkg::ertp_mode_t    mode_r;
  logic       pready_r;
  logic [31:0] prdata_r;
  logic       pslverr_r;
  logic       access;
  logic       wrEn;
  logic [7:0] wByte;
  logic [7:0] count_r;
  logic [7:0] reloadHold_r;
  logic [7:0] reloadAct_r;
  logic [7:0] duty_r;
  logic       flag_r;
  logic       ien_r;
  logic       clkSel_r;
  logic       enPrev_r;
  logic       enRise;
  logic [1:0] hSync_r;
  logic [1:0] lSync_r;
  logic       hLast_r;
  logic       lLast_r;
  logic       srcTick;
  logic [6:0] pre_r;
  logic [6:0] preMask;
  logic       tick;
  logic       overflow;
  logic       pwmHigh_r;
  logic       pwmLevel_r;
  logic       pwmPinActive_r;
  logic       irqReq_r;

  assign req    = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
  assign sel    = regSel(req.paddr);
  assign access = req.psel & req.penable & pready_r;
  assign wrEn   = access & req.pwrite;
  assign wByte  = req.pwdata[7:0];

  // apb handshake: one wait state in the access phase
  always_ff @(posedge clk) begin
    if (srst) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= req.psel & req.penable & ~pready_r;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
      if (req.psel & req.penable & ~pready_r) begin
        pslverr_r <= (sel == ertp_pkg::ERTP_SEL_NONE);
        if (!req.pwrite) begin
          unique case (sel)
            ertp_pkg::ERTP_SEL_MODE:   prdata_r[7:0] <= {mode_r[7:4], 2'b00, mode_r[1:0]};
            ertp_pkg::ERTP_SEL_COUNT:  prdata_r[7:0] <= count_r;
            ertp_pkg::ERTP_SEL_DUTY:   prdata_r[7:0] <= duty_r;
            ertp_pkg::ERTP_SEL_CTRL:   prdata_r[2:0] <= {clkSel_r, ien_r, flag_r};
            ertp_pkg::ERTP_SEL_RELOAD: prdata_r[7:0] <= 8'h00;
            ertp_pkg::ERTP_SEL_NONE:   prdata_r[7:0] <= 8'h00;
          endcase
        end
      end
    end
  end

  // oscillator synchronisers and edge detect
  always_ff @(posedge clk) begin
    if (srst) begin
      hSync_r <= 2'b00;
      lSync_r <= 2'b00;
      hLast_r <= 1'b0;
      lLast_r <= 1'b0;
    end else begin
      hSync_r <= {hSync_r[0], hoscIn};
      lSync_r <= {lSync_r[0], loscIn};
      hLast_r <= hSync_r[1];
      lLast_r <= lSync_r[1];
    end
  end

  assign srcTick = clkSel_r ? (lSync_r[1] & ~lLast_r) : (hSync_r[1] & ~hLast_r);

  // prescaler
  assign enRise  = mode_r.timerEnable & ~enPrev_r;
  assign preMask = 7'(7'h7f >> mode_r.prescaleSelect);
  assign tick    = mode_r.timerEnable & srcTick & ((pre_r & preMask) == preMask);
  assign overflow = tick & (count_r == ertp_pkg::FULL_SCALE);

  always_ff @(posedge clk) begin
    if (srst) begin
      enPrev_r <= 1'b0;
      pre_r    <= ertp_pkg::PRE_RST;
    end else begin
      enPrev_r <= mode_r.timerEnable;
      if (enRise || !mode_r.timerEnable) begin
        pre_r <= ertp_pkg::PRE_RST;
      end else if (srcTick) begin
        pre_r <= pre_r + 7'h01;
      end
    end
  end

  // mode register
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_r <= ertp_pkg::MODE_RST;
    end else begin
      if (wrEn && sel == ertp_pkg::ERTP_SEL_MODE) begin
        mode_r <= {wByte[7:4], 2'b00, wByte[1:0]};
      end
      if (overflow && mode_r.onePulseEnable && mode_r.pwmOutputEnable) begin
        mode_r.pwmOutputEnable <= 1'b0;
      end
    end
  end

  // counter and reload buffers
  always_ff @(posedge clk) begin
    if (srst) begin
      count_r <= ertp_pkg::COUNT_RST;
    end else if (overflow) begin
      count_r <= reloadHold_r;
    end else if (wrEn && sel == ertp_pkg::ERTP_SEL_COUNT) begin
      count_r <= wByte;
    end else if (tick) begin
      count_r <= count_r + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      reloadHold_r <= ertp_pkg::RELOAD_RST;
      reloadAct_r  <= ertp_pkg::RELOAD_RST;
    end else begin
      if (wrEn && sel == ertp_pkg::ERTP_SEL_RELOAD) begin
        reloadHold_r <= wByte;
      end
      if (overflow) begin
        reloadAct_r <= reloadHold_r;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      duty_r <= ertp_pkg::DUTY_RST;
    end else if (wrEn && sel == ertp_pkg::ERTP_SEL_DUTY) begin
      duty_r <= wByte;
    end
  end

  // flag, interrupt enable, clock select
  always_ff @(posedge clk) begin
    if (srst) begin
      flag_r   <= 1'b0;
      ien_r    <= 1'b0;
      clkSel_r <= 1'b0;
    end else begin
      if (wrEn && sel == ertp_pkg::ERTP_SEL_CTRL) begin
        flag_r   <= wByte[ertp_pkg::CTRL_FLAG_BIT] & flag_r;
        ien_r    <= wByte[ertp_pkg::CTRL_IEN_BIT];
        clkSel_r <= wByte[ertp_pkg::CTRL_CLK_BIT];
      end
      if (overflow) begin
        flag_r <= 1'b1;
      end
    end
  end

  // pwm generator
  always_ff @(posedge clk) begin
    if (srst) begin
      pwmHigh_r <= 1'b0;
    end else if (!mode_r.timerEnable) begin
      pwmHigh_r <= 1'b0;
    end else if (enRise) begin
      pwmHigh_r <= (duty_r > count_r);
    end else if (overflow) begin
      pwmHigh_r <= (duty_r > reloadHold_r);
    end else if (count_r == duty_r) begin
      pwmHigh_r <= 1'b0;
    end
  end

  // registered outputs
  always_ff @(posedge clk) begin
    if (srst) begin
      pwmLevel_r     <= 1'b0;
      pwmPinActive_r <= 1'b0;
      irqReq_r       <= 1'b0;
    end else begin
      pwmPinActive_r <= mode_r.timerEnable & mode_r.pwmOutputEnable;
      pwmLevel_r     <= pwmHigh_r & mode_r.timerEnable & mode_r.pwmOutputEnable;
      irqReq_r       <= flag_r & ien_r;
    end
  end

  assign prdata       = prdata_r;
  assign pready       = pready_r;
  assign pslverr      = pslverr_r;
  assign pwmLevel     = pwmLevel_r;
  assign pwmPinActive = pwmPinActive_r;
  assign irqReq       = irqReq_r;

endmodule : ertp_timer

/* shared/ertp_pkg.sv */
package ertp_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_MODE   = 10'h0a4;
  localparam logic [9:0] IDX_COUNT  = 10'h0a5;
  localparam logic [9:0] IDX_RELOAD = 10'h0a6;
  localparam logic [9:0] IDX_DUTY   = 10'h0a7;
  localparam logic [9:0] IDX_CTRL   = 10'h0a8;
  localparam int         ADDR_W     = 12;

  // mode register layout
  localparam int MODE_EN_BIT   = 7;
  localparam int MODE_RATE_LSB = 4;
  localparam int MODE_PO_BIT   = 1;
  localparam int MODE_PWM_BIT  = 0;

  // control/status register layout
  localparam int CTRL_FLAG_BIT = 0;
  localparam int CTRL_IEN_BIT  = 1;
  localparam int CTRL_CLK_BIT  = 2;

  // reset values and limits
  localparam logic [7:0] MODE_RST  = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] RELOAD_RST = 8'h00;
  localparam logic [7:0] DUTY_RST  = 8'h00;
  localparam logic [6:0] PRE_RST   = 7'h00;
  localparam logic [7:0] FULL_SCALE = 8'hff;
  localparam logic [2:0] RATE_MAX  = 3'h7;

  typedef enum logic [2:0] {
    ERTP_SEL_NONE,
    ERTP_SEL_MODE,
    ERTP_SEL_COUNT,
    ERTP_SEL_RELOAD,
    ERTP_SEL_DUTY,
    ERTP_SEL_CTRL
  } ertp_sel_t;

  typedef struct packed {
    logic       timerEnable;
    logic [2:0] prescaleSelect;
    logic [1:0] unused;
    logic       onePulseEnable;
    logic       pwmOutputEnable;
  } ertp_mode_t;

  typedef struct packed {
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ertp_apb_req_t;
endpackage : ertp_pkg

/* tb/ertp_timer_asserts.sv */
`timescale 1ns/1ps
module ertp_timer_asserts (
  // clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // apb slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pwm and interrupt
  input wire logic        pwmLevel,
  input wire logic        pwmPinActive,
  input wire logic        irqReq
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic       done;
  logic [9:0] idx;
  assign done = psel && penable && pready;
  assign idx  = paddr[11:2];
  property p_wait; $rose(penable) |-> !pready ##1 pready; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_err; pslverr |-> done; endproperty
  property p_unmap; done && !(idx inside {[ertp_pkg::IDX_MODE:ertp_pkg::IDX_CTRL]}) |-> pslverr; endproperty
  property p_wo; done && !pwrite && idx == ertp_pkg::IDX_RELOAD |-> prdata == 32'h0000_0000; endproperty
  property p_pin; pwmLevel |-> pwmPinActive; endproperty
  property p_off; done && pwrite && idx == ertp_pkg::IDX_MODE && !pwdata[0] |-> ##[1:3] !pwmPinActive; endproperty
  property p_irq; done && pwrite && idx == ertp_pkg::IDX_CTRL && !pwdata[1] |-> ##[1:3] !irqReq; endproperty
  a_wait: assert property (p_wait) else $error("bad wait state");
  a_pulse: assert property (p_pulse) else $error("long pready");
  a_err: assert property (p_err) else $error("stray pslverr");
  a_unmap: assert property (p_unmap) else $error("unmapped not refused");
  a_wo: assert property (p_wo) else $error("reload readable");
  a_pin: assert property (p_pin) else $error("pwm on idle pin");
  a_off: assert property (p_off) else $error("pin stays pwm");
  a_irq: assert property (p_irq) else $error("irq not masked");
  c_err: cover property (done && pslverr);
  c_irq: cover property ($rose(irqReq));
  c_pin: cover property ($fell(pwmPinActive));
endmodule : ertp_timer_asserts

bind ertp_timer ertp_timer_asserts u_chk (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pwmLevel(pwmLevel), .pwmPinActive(pwmPinActive), .irqReq(irqReq));

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  localparam logic [9:0] MD = ertp_pkg::IDX_MODE;
  localparam logic [9:0] CN = ertp_pkg::IDX_COUNT;
  localparam logic [9:0] RL = ertp_pkg::IDX_RELOAD;
  localparam logic [9:0] DU = ertp_pkg::IDX_DUTY;
  localparam logic [9:0] CT = ertp_pkg::IDX_CTRL;
  localparam logic [7:0] MODES [4] = '{8'hf1, 8'hf1, 8'hf3, 8'hf0};
  localparam int         HLO [4] = '{240, 0, 56, 0};
  localparam int         HHI [4] = '{272, 0, 72, 0};
  logic        clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, hoscIn = 0, loscIn = 0;
  logic        pready, pslverr, pwmLevel, pwmPinActive, irqReq;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [4:0]  osc = 5'h00;
  logic [16:0] q[$];
  logic [16:0] e;
  logic [7:0]  v;
  int          fails = 0, cmp_count = 0, h, k;

  ertp_timer dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .hoscIn(hoscIn), .loscIn(loscIn),
    .pwmLevel(pwmLevel), .pwmPinActive(pwmPinActive), .irqReq(irqReq));

  initial forever #2 clk = ~clk;

  // slow oscillators, 8 and 32 clocks a period
  always @(posedge clk) begin
    osc <= osc + 5'h01;
    hoscIn <= osc[2];
    loscIn <= osc[4];
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    cmp_count++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      fails++;
      $display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask : chk

  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d, input logic [16:0] x);
    int n;
    q.push_back(x);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {a, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (n >= 16) begin
      fails++;
      finish_test();
    end
  endtask : xfer

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    xfer(1'b1, a, d, 17'h0_0000);
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [7:0] lo, input logic [7:0] hi);
    xfer(1'b0, a, 8'h00, {1'b0, lo, hi});
  endtask : rd

  task automatic waitirq;
    int n;
    for (n = 0; irqReq !== 1'b1; n++) begin
      if (n == 400) begin
        fails++;
        finish_test();
      end
      @(posedge clk);
    end
  endtask : waitirq

  task automatic meas(input int n);
    h = 0;
    repeat (n) begin
      @(posedge clk);
      h += int'(pwmLevel === 1'b1);
    end
  endtask : meas

  // completed accesses against the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready) begin
      e = q.pop_front();
      chk(32'(pslverr), 32'(e[16]), 32'(e[16]));
      if (!pwrite) chk(prdata, 32'(e[15:8]), 32'(e[7:0]));
    end
  end

  initial begin
    void'($urandom(32'h2f14));
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (k = 0; k < 5; k++) rd(MD + 10'(k), 8'h00, 8'h00);
    xfer(1'b0, 10'h0a9, 8'h00, 17'h1_0000);
    xfer(1'b1, 10'h000, 8'h55, 17'h1_0000);
    v = 8'($urandom);
    wr(DU, v);
    rd(DU, v, v);
    wr(CN, v);
    repeat (64) @(posedge clk);
    rd(CN, v, v);
    $display("access test done");
    for (k = 0; k < 5; k++) begin
      wr(CT, (k == 4) ? 8'h04 : 8'h00);
      wr(CN, 8'h00);
      wr(MD, {1'b1, (k == 4) ? 3'h7 : 3'(k + 4), 4'h0});
      repeat (252) @(posedge clk);
      wr(MD, 8'h00);
      v = (k == 4) ? 8'h08 : 8'(4 << k);
      rd(CN, v - 8'h01, v);
    end
    $display("prescaler test done");
    wr(CT, 8'h02);
    wr(CN, 8'hfd);
    wr(RL, 8'hfd);
    wr(MD, 8'hf0);
    waitirq();
    wr(MD, 8'h70);
    rd(CT, 8'h03, 8'h03);
    rd(CN, 8'hfd, 8'hfe);
    wr(RL, 8'h80);
    rd(CN, 8'hfd, 8'hfe);
    wr(CT, 8'h02);
    rd(CT, 8'h02, 8'h02);
    chk(32'(irqReq), 0, 0);
    wr(MD, 8'hf0);
    waitirq();
    wr(MD, 8'h70);
    rd(CN, 8'h80, 8'h81);
    $display("reload test done");
    wr(CT, 8'h00);
    for (k = 0; k < 4; k++) begin
      wr(CN, 8'hf0);
      wr(RL, 8'hf0);
      wr(DU, (k == 1) ? 8'hf0 : 8'hf8);
      wr(MD, MODES[k] & 8'h7f);
      wr(MD, MODES[k]);
      meas(512);
      chk(h, HLO[k], HHI[k]);
      chk(32'(pwmPinActive), 32'(k < 2), 32'(k < 2));
      v = (k == 2) ? 8'hf2 : MODES[k];
      rd(MD, v, v);
      wr(MD, 8'h00);
    end
    $display("pwm test done");
    finish_test();
  end
endmodule : tb_top
